/* logic/proximity_measure_sequencer.v */
// Purpose: Runs LED-off and LED-on conversions per proximity channel and reports differences
// Assumes: External converter answers adc_start with adc_done and adc_data
// Notes: Host configuration arrives over a simple write strobe, not a register bus
`timescale 1ns/1ps
`include "proximity_measure_sequencer_defines.vh"

// Function
// - The LED pulse lasts 25.6 us at gain zero and doubles with each gain step.
// - Each channel converts first with LEDs off and then with the LEDs on.
// - The LED-on conversion starts right after the LED-off one, within 25.6 us.
// - The channel result is the LED-on value minus the LED-off value.
// - One burst measures all enabled channels and then the block returns to sleep.
// - After reset channel one drives LED one, two drives two, three drives three.
// - Each channel may route to any subset of the drives, all pulsed together.
// - Channels are always measured in order one, two, three.
// - During the pulse each selected drive sinks its regulated current.
// - A four-bit current code per channel, all ones being the highest current.
module proximity_measure_sequencer #(
    parameter ADC_W = `ADC_WIDTH,
    parameter GAIN_W = `GAIN_WIDTH,
    parameter CUR_W = `CURRENT_WIDTH,
    parameter PULSE_BASE_CYCLES = `LED_PULSE_BASE_NS / `CLK_PERIOD_NS,
    parameter GAP_MAX_CYCLES = `CONV_GAP_MAX_NS / `CLK_PERIOD_NS
) (
    clk,
    reset,
    measure_start,
    cfg_write,
    cfg_chan,
    cfg_enable,
    cfg_route,
    cfg_current,
    cfg_gain,
    adc_start,
    adc_led_phase,
    adc_done,
    adc_data,
    led_sink_en,
    led_current_code,
    result_one,
    result_two,
    result_three,
    result_valid,
    gap_fault,
    sleeping
);
    input wire clk;
    input wire reset;
    input wire measure_start;
    input wire cfg_write;
    input wire [1:0] cfg_chan;
    input wire cfg_enable;
    input wire [2:0] cfg_route;
    input wire [CUR_W-1:0] cfg_current;
    input wire [GAIN_W-1:0] cfg_gain;
    output wire adc_start;
    output wire adc_led_phase;
    input wire adc_done;
    input wire [ADC_W-1:0] adc_data;
    output reg [2:0] led_sink_en;
    output reg [3*CUR_W-1:0] led_current_code;
    output reg [ADC_W:0] result_one;
    output reg [ADC_W:0] result_two;
    output reg [ADC_W:0] result_three;
    output reg result_valid;
    output reg gap_fault;
    output wire sleeping;

    localparam ST_SLEEP = 3'h0;
    localparam ST_PICK = 3'h1;
    localparam ST_OFF_CONV = 3'h2;
    localparam ST_ON_CONV = 3'h3;
    localparam ST_STORE = 3'h4;

    localparam GAP_W = 16;
    localparam [GAP_W-1:0] GAP_MAX = GAP_MAX_CYCLES;

    // ==========================================================
    // Configuration held per channel, plus one shared gain
    reg [2:0] enable_ff;
    reg [2:0] route_one_ff;
    reg [2:0] route_two_ff;
    reg [2:0] route_three_ff;
    reg [CUR_W-1:0] current_one_ff;
    reg [CUR_W-1:0] current_two_ff;
    reg [CUR_W-1:0] current_three_ff;
    reg [GAIN_W-1:0] gain_ff;

    reg [2:0] state_ff;
    reg [1:0] chan_ff;
    reg [ADC_W-1:0] ambient_ff;
    reg [ADC_W-1:0] lit_ff;
    reg on_adc_seen_ff;
    reg pulse_seen_ff;
    reg start_ff;
    reg [GAP_W-1:0] gap_ff;

    wire pulse_active;
    wire pulse_done;
    wire [2:0] chan_route;
    wire [CUR_W-1:0] chan_current;
    wire [1:0] first_chan;
    wire [1:0] next_chan;
    wire [ADC_W:0] diff;

    // Lowest enabled channel at or after a given index; 2'h3 means none
    function [1:0] next_enabled;
        input [2:0] en;
        input [1:0] from;
        begin
            if (from == `CHAN_ONE && en[0])
                next_enabled = `CHAN_ONE;
            else if (from <= `CHAN_TWO && en[1])
                next_enabled = `CHAN_TWO;
            else if (from <= `CHAN_THREE && en[2])
                next_enabled = `CHAN_THREE;
            else
                next_enabled = 2'h3;
        end
    endfunction

    always @(posedge clk) begin
        if (reset) begin
            enable_ff <= `ENABLE_RST;
            route_one_ff <= `ROUTE_ONE_RST;
            route_two_ff <= `ROUTE_TWO_RST;
            route_three_ff <= `ROUTE_THREE_RST;
            current_one_ff <= `CURRENT_RST;
            current_two_ff <= `CURRENT_RST;
            current_three_ff <= `CURRENT_RST;
            gain_ff <= `GAIN_RST;
        end else if (cfg_write && state_ff == ST_SLEEP) begin
            // Changes during a burst are dropped so one burst uses one setting
            gain_ff <= cfg_gain;
            if (cfg_chan == `CHAN_ONE) begin
                enable_ff[0] <= cfg_enable;
                route_one_ff <= cfg_route;
                current_one_ff <= cfg_current;
            end else if (cfg_chan == `CHAN_TWO) begin
                enable_ff[1] <= cfg_enable;
                route_two_ff <= cfg_route;
                current_two_ff <= cfg_current;
            end else if (cfg_chan == `CHAN_THREE) begin
                enable_ff[2] <= cfg_enable;
                route_three_ff <= cfg_route;
                current_three_ff <= cfg_current;
            end
        end
    end

    assign chan_route = (chan_ff == `CHAN_ONE) ? route_one_ff :
                        (chan_ff == `CHAN_TWO) ? route_two_ff : route_three_ff;
    assign chan_current = (chan_ff == `CHAN_ONE) ? current_one_ff :
                          (chan_ff == `CHAN_TWO) ? current_two_ff : current_three_ff;
    assign first_chan = next_enabled(enable_ff, `CHAN_ONE);
    assign next_chan = (chan_ff == `CHAN_THREE) ? 2'h3 :
                       next_enabled(enable_ff, chan_ff + 2'h1);
    assign diff = {1'b0, lit_ff} - {1'b0, ambient_ff};

    // ==========================================================
    // LED pulse timing
    led_pulse_timer #(
        .BASE_CYCLES(PULSE_BASE_CYCLES),
        .GAIN_W(GAIN_W),
        .CNT_W(24)
    ) u_pulse (
        .clk(clk),
        .reset(reset),
        .start(start_ff && state_ff == ST_ON_CONV),
        .gain(gain_ff),
        .active(pulse_active),
        .done(pulse_done)
    );

    // ==========================================================
    // Burst sequencer
    assign adc_start = start_ff;
    assign adc_led_phase = (state_ff == ST_ON_CONV);
    assign sleeping = (state_ff == ST_SLEEP);

    always @(posedge clk) begin
        if (reset) begin
            state_ff <= ST_SLEEP;
            chan_ff <= `CHAN_ONE;
            ambient_ff <= {ADC_W{1'b0}};
            lit_ff <= {ADC_W{1'b0}};
            on_adc_seen_ff <= 1'b0;
            pulse_seen_ff <= 1'b0;
            start_ff <= 1'b0;
            gap_ff <= {GAP_W{1'b0}};
            gap_fault <= 1'b0;
            result_one <= {(ADC_W+1){1'b0}};
            result_two <= {(ADC_W+1){1'b0}};
            result_three <= {(ADC_W+1){1'b0}};
            result_valid <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            result_valid <= 1'b0;
            case (state_ff)
                ST_SLEEP: begin
                    if (measure_start) begin
                        state_ff <= ST_PICK;
                        chan_ff <= first_chan;
                        gap_fault <= 1'b0;
                    end
                end
                ST_PICK: begin
                    if (chan_ff == 2'h3) begin
                        state_ff <= ST_SLEEP;
                        result_valid <= 1'b1;
                    end else begin
                        state_ff <= ST_OFF_CONV;
                        start_ff <= 1'b1;
                    end
                end
                ST_OFF_CONV: begin
                    if (adc_done && !start_ff) begin
                        ambient_ff <= adc_data;
                        state_ff <= ST_ON_CONV;
                        start_ff <= 1'b1;
                        on_adc_seen_ff <= 1'b0;
                        pulse_seen_ff <= 1'b0;
                        gap_ff <= {GAP_W{1'b0}};
                    end
                end
                ST_ON_CONV: begin
                    // Gap watch covers the ambient sample's age until the lit result
                    if (!on_adc_seen_ff && gap_ff != GAP_MAX) begin
                        gap_ff <= gap_ff + {{(GAP_W-1){1'b0}}, 1'b1};
                    end
                    if (adc_done && !start_ff && !on_adc_seen_ff) begin
                        lit_ff <= adc_data;
                        on_adc_seen_ff <= 1'b1;
                        if (gap_ff == GAP_MAX) begin
                            gap_fault <= 1'b1;
                        end
                    end
                    if (pulse_done) begin
                        pulse_seen_ff <= 1'b1;
                    end
                    if ((on_adc_seen_ff || (adc_done && !start_ff)) &&
                        (pulse_seen_ff || pulse_done)) begin
                        state_ff <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (chan_ff == `CHAN_ONE) begin
                        result_one <= diff;
                    end else if (chan_ff == `CHAN_TWO) begin
                        result_two <= diff;
                    end else begin
                        result_three <= diff;
                    end
                    chan_ff <= next_chan;
                    state_ff <= ST_PICK;
                end
                default: begin
                    state_ff <= ST_SLEEP;
                end
            endcase
        end
    end

    // ==========================================================
    // LED drives: every selected drive sinks the channel's current together
    genvar d;
    generate
        for (d = 0; d < 3; d = d + 1) begin : g_drive
            always @(posedge clk) begin
                if (reset) begin
                    led_sink_en[d] <= 1'b0;
                    led_current_code[d*CUR_W +: CUR_W] <= {CUR_W{1'b0}};
                end else if ((pulse_active && !pulse_done) ||
                             (start_ff && state_ff == ST_ON_CONV)) begin
                    led_sink_en[d] <= chan_route[d];
                    led_current_code[d*CUR_W +: CUR_W] <=
                        chan_route[d] ? chan_current : {CUR_W{1'b0}};
                end else begin
                    led_sink_en[d] <= 1'b0;
                    led_current_code[d*CUR_W +: CUR_W] <= {CUR_W{1'b0}};
                end
            end
        end
    endgenerate
endmodule // proximity_measure_sequencer

/* logic/proximity_measure_sequencer_defines.vh */
// Purpose: Shared constants for the proximity measurement sequencer
// Assumes: 200 MHz clock
// Notes: Times are given in ns and converted to cycles by the modules
`ifndef PROXIMITY_MEASURE_SEQUENCER_DEFINES_VH
`define PROXIMITY_MEASURE_SEQUENCER_DEFINES_VH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 5
`define LED_PULSE_BASE_NS 25600
`define CONV_GAP_MAX_NS 25600

// ==========================================================
// Widths
`define ADC_WIDTH 16
`define GAIN_WIDTH 3
`define CURRENT_WIDTH 4
`define NUM_CHANNELS 3

// ==========================================================
// Reset values
`define GAIN_RST 3'h0
`define ENABLE_RST 3'h7
`define CURRENT_RST 4'hF
`define ROUTE_ONE_RST 3'h1
`define ROUTE_TWO_RST 3'h2
`define ROUTE_THREE_RST 3'h4

// ==========================================================
// Channel indices
`define CHAN_ONE 2'h0
`define CHAN_TWO 2'h1
`define CHAN_THREE 2'h2

`endif

/* logic/led_pulse_timer.v */
// Purpose: Times one LED pulse whose width scales by two to the gain exponent
// Assumes: start is a one-cycle pulse while idle
// Notes: Counter is wide enough for the largest gain
`timescale 1ns/1ps
`include "proximity_measure_sequencer_defines.vh"

module led_pulse_timer #(
    parameter BASE_CYCLES = 5120,
    parameter GAIN_W = 3,
    parameter CNT_W = 24
) (
    clk,
    reset,
    start,
    gain,
    active,
    done
);
    input wire clk;
    input wire reset;
    input wire start;
    input wire [GAIN_W-1:0] gain;
    output wire active;
    output reg done;

    localparam [CNT_W-1:0] BASE = BASE_CYCLES;

    reg [CNT_W-1:0] remain_ff;
    reg active_ff;

    assign active = active_ff;

    // ==========================================================
    // Pulse counter
    always @(posedge clk) begin
        if (reset) begin
            remain_ff <= {CNT_W{1'b0}};
            active_ff <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !active_ff) begin
                remain_ff <= (BASE << gain) - {{(CNT_W-1){1'b0}}, 1'b1};
                active_ff <= 1'b1;
            end else if (active_ff) begin
                if (remain_ff == {CNT_W{1'b0}}) begin
                    active_ff <= 1'b0;
                    done <= 1'b1;
                end else begin
                    remain_ff <= remain_ff - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // led_pulse_timer

/* tb/proximity_measure_sequencer_chk.sv */
// Purpose: Port-level checks for the proximity measurement sequencer
// Assumes: Bound to the sequencer; partner answers only after adc_start
// Notes: Pulse length is judged by a run counter, allowing two cycles of slack
`timescale 1ns/1ps
module proximity_measure_sequencer_chk #(
    parameter ADC_W = 16,
    parameter GAIN_W = 3,
    parameter CUR_W = 4,
    parameter PULSE_BASE_CYCLES = 5120
) (
    input wire clk,
    input wire reset,
    input wire measure_start,
    input wire cfg_write,
    input wire [GAIN_W-1:0] cfg_gain,
    input wire adc_start,
    input wire adc_led_phase,
    input wire adc_done,
    input wire [2:0] led_sink_en,
    input wire [3*CUR_W-1:0] led_current_code,
    input wire [ADC_W:0] result_one,
    input wire result_valid,
    input wire gap_fault,
    input wire sleeping
);
    // ==========================================================
    // Helper logic
    reg [GAIN_W-1:0] gain_ff;
    reg [31:0] run_ff;
    wire lit = |led_sink_en;
    always @(posedge clk) begin
        if (reset) begin
            gain_ff <= 0;
            run_ff <= 0;
        end else begin
            if (cfg_write && sleeping) begin
                gain_ff <= cfg_gain;
            end
            run_ff <= lit ? run_ff + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Assertions
    a_pulse_width: assert property ($fell(lit) |-> run_ff >= (PULSE_BASE_CYCLES << gain_ff)
        && run_ff <= (PULSE_BASE_CYCLES << gain_ff) + 2) else $error("LED pulse length wrong");
    a_dark_ambient: assert property (adc_start && !adc_led_phase |-> !lit)
        else $error("LEDs on during ambient conversion");
    a_lit_launch: assert property ($rose(lit) |-> $past(adc_start && adc_led_phase))
        else $error("LEDs rose without lit conversion start");
    a_lit_follows: assert property (adc_done && !adc_start && !adc_led_phase && !sleeping
        |=> adc_start && adc_led_phase) else $error("Lit conversion not back to back");
    a_fault_cleared: assert property (sleeping && measure_start |=> !gap_fault)
        else $error("Gap flag not cleared at burst start");
    a_burst_begins: assert property ($fell(sleeping) |=> (adc_start && !adc_led_phase)
        || result_valid) else $error("Burst did not open with ambient conversion");
    a_start_awake: assert property (adc_start |-> !sleeping)
        else $error("Conversion requested while asleep");
    a_valid_sleep: assert property (result_valid |-> ##[0:1] sleeping)
        else $error("No return to sleep after burst");
    a_code_off_zero: assert property ((led_sink_en[0] || led_current_code[CUR_W-1:0] == 0)
        && (led_sink_en[1] || led_current_code[2*CUR_W-1:CUR_W] == 0)
        && (led_sink_en[2] || led_current_code[3*CUR_W-1:2*CUR_W] == 0))
        else $error("Current code on idle drive");
    a_result_held: assert property (sleeping && $past(sleeping) |-> $stable(result_one))
        else $error("Result changed while asleep");
    c_burst_done: cover property (result_valid);
    c_all_drives: cover property (led_sink_en == 3'h7);
    c_gap_seen: cover property ($rose(gap_fault));
    c_busy_write: cover property (cfg_write && !sleeping);
endmodule // proximity_measure_sequencer_chk

bind proximity_measure_sequencer proximity_measure_sequencer_chk #(.ADC_W(ADC_W),
    .GAIN_W(GAIN_W), .CUR_W(CUR_W), .PULSE_BASE_CYCLES(PULSE_BASE_CYCLES)) chk_u (
    .clk(clk), .reset(reset), .measure_start(measure_start), .cfg_write(cfg_write),
    .cfg_gain(cfg_gain), .adc_start(adc_start), .adc_led_phase(adc_led_phase),
    .adc_done(adc_done), .led_sink_en(led_sink_en), .led_current_code(led_current_code),
    .result_one(result_one), .result_valid(result_valid), .gap_fault(gap_fault),
    .sleeping(sleeping));

/* tb/proximity_adc_model.sv */
// Purpose: Converter and LED light model facing the sequencer
// Assumes: Latencies of at least two cycles so the LEDs are lit when sampled
// Notes: Data toggles outside the answer cycle so stale values are never trusted
`timescale 1ns/1ps
module proximity_adc_model (
    input wire clk,
    input wire reset,
    input wire adc_start,
    input wire adc_led_phase,
    input wire [2:0] led_sink_en,
    input wire [15:0] amb,
    input wire [7:0] lat_off,
    input wire [7:0] lat_on,
    output reg adc_done = 1'b0,
    output reg [15:0] adc_data = 16'h0000
);
    reg busy_ff;
    reg lit_ff;
    reg [7:0] cnt_ff;
    always @(posedge clk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (reset) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h00;
        end else if (adc_start) begin
            busy_ff <= 1'b1;
            lit_ff <= adc_led_phase;
            cnt_ff <= adc_led_phase ? lat_on : lat_off;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
                busy_ff <= 1'b0;
                adc_done <= 1'b1;
                // Each lit drive adds its own light on top of ambient
                adc_data <= lit_ff ? amb + {5'h00, led_sink_en, 8'h00} : amb;
            end
        end
    end
endmodule // proximity_adc_model

/* tb/proximity_measure_sequencer_tb_top.sv */
// Purpose: Self-checking bench for the proximity measurement sequencer
// Assumes: Short pulse and gap counts to keep the run brief
// Notes: A write during every burst with an enabled channel must be refused
`timescale 1ns/1ps
module proximity_measure_sequencer_tb_top;
    reg clk = 0;
    reg reset = 1;
    reg measure_start = 0;
    reg cfg_write = 0;
    reg [1:0] cfg_chan = 0;
    reg cfg_enable = 0;
    reg [2:0] cfg_route = 0;
    reg [3:0] cfg_current = 0;
    reg [2:0] cfg_gain = 0;
    reg [15:0] amb = 16'h0100;
    reg [7:0] lat_off = 8'h02;
    reg [7:0] lat_on = 8'h02;
    wire adc_start, adc_led_phase, adc_done, result_valid, gap_fault, sleeping;
    wire [15:0] adc_data;
    wire [2:0] led_sink_en;
    wire [11:0] led_current_code;
    wire [16:0] res [0:2];
    integer seed = 15580;
    integer error_cnt = 0;
    integer compares = 0;
    integer vld_cnt = 0;
    integer i;
    reg [31:0] r;
    reg en [0:2];
    reg [2:0] rt [0:2];
    reg [3:0] cu [0:2];
    reg [16:0] ex [0:2];
    reg [2:0] gain_v = 0;
    reg on_q = 0;
    logic [14:0] seq_q [$];
    always #2.5 clk = ~clk;
    proximity_measure_sequencer #(.PULSE_BASE_CYCLES(16), .GAP_MAX_CYCLES(64)) dut_u (
        .clk(clk), .reset(reset), .measure_start(measure_start), .cfg_write(cfg_write),
        .cfg_chan(cfg_chan), .cfg_enable(cfg_enable), .cfg_route(cfg_route),
        .cfg_current(cfg_current), .cfg_gain(cfg_gain), .adc_start(adc_start),
        .adc_led_phase(adc_led_phase), .adc_done(adc_done), .adc_data(adc_data),
        .led_sink_en(led_sink_en), .led_current_code(led_current_code), .result_one(res[0]),
        .result_two(res[1]), .result_three(res[2]), .result_valid(result_valid),
        .gap_fault(gap_fault), .sleeping(sleeping));
    proximity_adc_model adc_u (.clk(clk), .reset(reset), .adc_start(adc_start),
        .adc_led_phase(adc_led_phase), .led_sink_en(led_sink_en), .amb(amb),
        .lat_off(lat_off), .lat_on(lat_on), .adc_done(adc_done), .adc_data(adc_data));
    // ==========================================================
    // Pulse recorder: drive pattern and codes at each LED turn-on
    always @(posedge clk) begin
        if (|led_sink_en && !on_q) begin
            seq_q.push_back({led_current_code, led_sink_en});
        end
        on_q <= |led_sink_en;
        // Counted here so each burst can be checked for exactly one result_valid, even an empty one
        if (result_valid === 1'b1) begin
            vld_cnt <= vld_cnt + 1;
        end
    end
    function [11:0] exp_code(input [2:0] rr, input [3:0] c);
        exp_code = {rr[2] ? c : 4'h0, rr[1] ? c : 4'h0, rr[0] ? c : 4'h0};
    endfunction
    task chk(input string nm, input [16:0] e, input [16:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cfg(input [1:0] c, input e, input [2:0] rr, input [3:0] k, input ok);
        @(posedge clk);
        cfg_write <= 1'b1;
        cfg_chan <= c;
        cfg_enable <= e;
        cfg_route <= rr;
        cfg_current <= k;
        cfg_gain <= ok ? gain_v : ~gain_v;
        @(posedge clk);
        cfg_write <= 1'b0;
        if (ok && c != 2'h3) begin
            en[c] = e;
            rt[c] = rr;
            cu[c] = k;
        end
    endtask
    task burst(input [7:0] lo, input [7:0] ln);
        integer n, k, j, v0;
        reg [14:0] s;
        r = $random(seed);
        amb <= r[15:0] & 16'h7FFF;
        lat_off <= lo;
        lat_on <= ln;
        seq_q.delete();
        v0 = vld_cnt;
        @(posedge clk);
        measure_start <= 1'b1;
        @(posedge clk);
        measure_start <= 1'b0;
        // A burst with no channel is asleep again here, so a write would land
        if (en[0] || en[1] || en[2]) begin
            cfg(r[17:16], 1'b0, 3'h0, 4'h0, 1'b0); // Busy write, must be ignored
        end
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (vld_cnt == v0 && n < 2000);
        chk("result_valid", 17'h1, 17'(vld_cnt - v0));
        chk("gap_fault", {16'h0, ln > 8'd64}, {16'h0, gap_fault});
        k = 0;
        for (j = 0; j < 3; j++) begin
            if (en[j]) begin
                ex[j] = {6'h00, rt[j], 8'h00};
                s = (k < seq_q.size()) ? seq_q[k] : 15'h0;
                k++;
                chk("drives", {2'h0, exp_code(rt[j], cu[j]), rt[j]}, {2'h0, s});
            end
            chk("result", ex[j], res[j]);
        end
        chk("pulse_count", 17'(k), 17'(seq_q.size()));
    endtask
    task results;
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        for (i = 0; i < 3; i++) begin
            en[i] = 1'b1;
            rt[i] = 3'h1 << i;
            cu[i] = 4'hF;
            ex[i] = 17'h0;
        end
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        burst(8'h03, 8'h05);
        repeat (6) begin
            for (i = 0; i < 3; i++) begin
                r = $random(seed);
                rt[i] = (r[4:2] == 3'h0) ? 3'h4 : r[4:2];
                // Three drives at once get a low code to stay within the total limit
                cu[i] = (rt[i] == 3'h7) ? 4'h4 : r[8:5];
                cfg(i[1:0], r[0] | r[1], rt[i], cu[i], 1'b1);
            end
            burst(8'h02 + {5'h0, r[11:9]}, 8'h02 + {5'h0, r[14:12]});
        end
        gain_v = 3'h3;
        cfg(2'h0, 1'b1, 3'h7, 4'h4, 1'b1);
        cfg(2'h1, 1'b0, 3'h2, 4'h9, 1'b1);
        cfg(2'h2, 1'b1, 3'h1, 4'hF, 1'b1);
        burst(8'h02, 8'd70);
        gain_v = 3'h0;
        cfg(2'h3, 1'b0, 3'h0, 4'h0, 1'b1);
        burst(8'h02, 8'h02);
        // No channel enabled: the burst ends at once and every result stays
        cfg(2'h0, 1'b0, 3'h1, 4'h1, 1'b1);
        cfg(2'h2, 1'b0, 3'h4, 4'h2, 1'b1);
        burst(8'h02, 8'h02);
        results;
    end
    initial begin
        #300000;
        error_cnt++;
        results;
    end
endmodule // proximity_measure_sequencer_tb_top
